// >>> verification/rxafc_link_partner.sv
// Remote station model: sends each requested pause frame after a wire delay
`timescale 1ns/1ps
module rxafc_link_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pause_req,
    input  wire logic [15:0] pause_time,
    input  wire logic [7:0]  delay,
    output logic             pause_done,
    output int               n_frames,
    output logic      [15:0] last_time
);
    logic [7:0] wait_cnt;
    // Done pulses once; the request is ignored while done is still up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= '0;
            pause_done <= 1'b0;
            n_frames <= 0;
            last_time <= '0;
        end else begin
            pause_done <= 1'b0;
            if (pause_req && !pause_done) begin
                wait_cnt <= wait_cnt + 8'h1;
                if (wait_cnt >= delay) begin
                    wait_cnt <= '0;
                    pause_done <= 1'b1;
                    n_frames <= n_frames + 1;
                    last_time <= pause_time;
                end
            end else if (!pause_req) begin
                // An aborted request must not shorten the next one
                wait_cnt <= '0;
            end
        end
    end
endmodule

// >>> verification/rxafc_monitor.sv
// Port checker for the receive flow controller
`timescale 1ns/1ps
module rxafc_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_enabled,
    input wire logic        full_duplex,
    input wire logic [15:0] pause_time_value,
    input wire logic        pause_done,
    input wire logic        pause_req,
    input wire logic [15:0] pause_time,
    input wire logic        jam
);
    logic [16:0] jam_cycles;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Length of the running jam; even the shortest code needs 500 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            jam_cycles <= '0;
        else
            jam_cycles <= jam ? jam_cycles + 17'h1 : 17'h0;
    end
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    pause_tx_a: assert property ($rose(pause_req) |-> $past(tx_enabled))
        else $error("pause while transmitter off");
    jam_tx_a: assert property ($rose(jam) |-> $past(tx_enabled, 2))
        else $error("jam while transmitter off");
    pause_fd_a: assert property ($rose(pause_req) |-> $past(full_duplex))
        else $error("pause in half duplex");
    pause_hold_a: assert property (pause_req && !pause_done && tx_enabled ##1 tx_enabled
        |-> pause_req) else $error("pause request dropped early");
    pause_value_a: assert property ($rose(pause_req)
        |-> pause_time == pause_time_value || pause_time == 16'h0) else $error("bad pause time");
    jam_hd_a: assert property ($rose(jam) |-> !$past(full_duplex, 2))
        else $error("jam in full duplex");
    jam_min_a: assert property ($fell(jam) && tx_enabled && !full_duplex
        |-> jam_cycles >= 17'h001F4) else $error("jam too short");
endmodule
bind rxafc_core rxafc_monitor i_rxafc_monitor (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pready           (pready),
    .pslverr          (pslverr),
    .tx_enabled       (tx_enabled),
    .full_duplex      (full_duplex),
    .pause_time_value (pause_time_value),
    .pause_done       (pause_done),
    .pause_req        (pause_req),
    .pause_time       (pause_time),
    .jam              (jam)
);

// >>> verification/tb_rxafc_core.sv
// Self-checking bench for the receive flow controller
`timescale 1ns/1ps
module tb_rxafc_core;
    import rxafc_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [13:0]  rx_fifo_bytes;
    logic         tx_enabled, full_duplex, speed_10m, pause_done, pause_req, jam;
    logic [15:0]  pause_time, last_time, pause_time_value;
    logic [7:0]   delay;
    rxafc_rx_ev_t rx_ev;
    int           n_fail, total_checks, n_frames, len;

    rxafc_core i_rxafc_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_fifo_bytes, .tx_enabled, .full_duplex, .speed_10m,
        .pause_time_value, .rx_ev, .pause_done, .pause_req, .pause_time, .jam);
    rxafc_link_partner i_rxafc_link_partner (.pclk, .presetn, .pause_req, .pause_time,
        .delay, .pause_done, .n_frames, .last_time);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // low level kept below high level
    task automatic cfg(input logic [7:0] hi, lo, input logic [3:0] dur, sel);
        apb(1'b1, RXAFC_CFG_OFFSET, {8'h00, hi, lo, dur, sel});
    endtask
    // Preamble, then address decode only when a frame type is given
    task automatic frame(input logic [2:0] t);
        @(posedge pclk);
        rx_ev <= 5'b10000;
        @(posedge pclk);
        rx_ev <= {1'b0, t != 3'b000, t};
        @(posedge pclk);
        rx_ev <= '0;
    endtask
    task automatic hd(input logic [3:0] sel, dur, input logic spd, input logic [2:0] t,
                      input int exp);
        int i;
        speed_10m <= spd;
        cfg(8'h04, 8'h02, dur, sel);
        frame(t);
        len = 0;
        for (i = 0; i < 10 && jam !== 1'b1; i++) @(posedge pclk);
        while (jam === 1'b1) begin
            len++;
            @(posedge pclk);
        end
        chk(len, exp);
    endtask
    task automatic t_regs();
        apb(1'b0, RXAFC_CFG_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, RXAFC_CFG_OFFSET, 32'hFFFFFFFF);
        apb(1'b1, 12'h0B0, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, RXAFC_CFG_OFFSET, 32'h0);
        chk(rd, 32'h00FFFFFF);
    endtask
    task automatic t_pause();
        full_duplex <= 1'b1;
        tx_enabled <= 1'b1;
        delay <= 8'h28;
        pause_time_value <= 16'hC35A;
        rx_fifo_bytes <= 14'h0FF;
        cfg(8'h04, 8'h02, 4'h0, 4'h1);
        frame(3'b000);
        repeat (60) @(posedge pclk);
        chk(n_frames, 0);
        rx_fifo_bytes <= 14'h100;
        frame(3'b000);
        repeat (60) @(posedge pclk);
        chk(last_time, 16'hC35A);
        delay <= 8'h00;
        frame(3'b000);
        rx_fifo_bytes <= 14'h080;
        repeat (60) @(posedge pclk);
        chk(n_frames, 1);
        rx_fifo_bytes <= 14'h07F;
        repeat (20) @(posedge pclk);
        chk({n_frames[15:0], last_time}, 32'h00020000);
    endtask
    task automatic t_refuse();
        cfg(8'h04, 8'h02, 4'h0, 4'h1);
        delay <= 8'h28;
        rx_fifo_bytes <= 14'h12C;
        frame(3'b000);
        repeat (5) @(posedge pclk);
        chk(pause_req, 1'b1);
        // Pause cut off before it went out: no zero-time pause may follow
        tx_enabled <= 1'b0;
        repeat (5) @(posedge pclk);
        tx_enabled <= 1'b1;
        rx_fifo_bytes <= 14'h00A;
        repeat (60) @(posedge pclk);
        chk(n_frames, 2);
        rx_fifo_bytes <= 14'h12C;
        repeat (20) @(posedge pclk);
        rx_fifo_bytes <= 14'h00A;
        repeat (20) @(posedge pclk);
        chk(n_frames, 2);
        tx_enabled <= 1'b0;
        rx_fifo_bytes <= 14'h12C;
        frame(3'b000);
        repeat (60) @(posedge pclk);
        chk(n_frames, 2);
        tx_enabled <= 1'b1;
        cfg(8'h04, 8'h02, 4'h0, 4'h8);
        frame(3'b100);
        repeat (60) @(posedge pclk);
        chk(n_frames, 2);
    endtask
    // Half duplex: cycles are microseconds times 100, plus 220 at 10 Mb/s
    task automatic t_jam();
        full_duplex <= 1'b0;
        hd(4'h8, 4'h0, 1'b0, 3'b100, 500);
        hd(4'h4, 4'h0, 1'b0, 3'b010, 500);
        hd(4'h2, 4'h0, 1'b0, 3'b001, 500);
        hd(4'h8, 4'h0, 1'b0, 3'b010, 0);
        hd(4'h1, 4'h0, 1'b0, 3'b000, 500);
        hd(4'h9, 4'h3, 1'b0, 3'b010, 2500);
        hd(4'h2, 4'h1, 1'b1, 3'b001, 1220);
        hd(4'h4, 4'h4, 1'b0, 3'b010, 5000);
        tx_enabled <= 1'b0;
        hd(4'h1, 4'h0, 1'b0, 3'b000, 0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Free-running 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Watchdog well past the longest expected run
    initial begin
        #800000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, tx_enabled, full_duplex, speed_10m} = '0;
        {paddr, pwdata, rx_fifo_bytes, delay, pause_time_value} = '0;
        rx_ev = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pause();
        t_refuse();
        t_jam();
        tally_and_finish();
    end
endmodule

// >>> verilog/rxafc_core.sv
// Automatic receive flow control: thresholds, pause requests and half-duplex jam
//
// How it works
// - No pause frame or jam while the MAC transmitter is disabled.
// - High threshold in bits 23:16, 64-byte units, triggers flow control.
// - Full duplex: one pause frame per high crossing, time from pause register.
// - Half duplex: jam each selected incoming frame for the programmed duration.
// - Low threshold in bits 15:8; falling below sends zero-time pause.
// - Zero-time pause only after high reached and a pause was sent.
// - Bits 7:4 select jam duration; unused in full duplex.
// - Bit 3 jams multicast frames in half duplex.
// - Bit 2 jams broadcast frames in half duplex.
// - Bit 1 jams frames addressed to this station in half duplex.
// - Bit 0 reacts to any frame; alone enables full-duplex pause.
// - Any-frame mode reacts at valid preamble, without address decode.
// - Any-frame bit overrides the bits 3:1 selections.
// - Duration codes map 5us to 600us, plus 2.2us at 10 Mb/s.
`timescale 1ns/1ps
module rxafc_core
    import rxafc_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [13:0]        rx_fifo_bytes,
    input  wire logic               tx_enabled,
    input  wire logic               full_duplex,
    input  wire logic               speed_10m,
    input  wire logic [15:0]        pause_time_value,
    input  wire rxafc_pkg::rxafc_rx_ev_t rx_ev,
    input  wire logic               pause_done,
    output logic                    pause_req,
    output logic      [15:0]        pause_time,
    output logic                    jam
);
    import rxafc_pkg::*;

    logic [23:0]     cfg;
    logic [7:0]      flow_high_level;
    logic [7:0]      flow_low_level;
    logic [3:0]      jam_duration;
    logic            trigger_on_multicast;
    logic            trigger_on_broadcast;
    logic            trigger_on_own_address;
    logic            trigger_on_any_frame;
    logic            apb_access;
    logic            cfg_hit;
    logic            above_high;
    logic            below_low;
    logic            frame_match;
    logic            jam_start;
    logic            jam_busy;
    logic            hd_active;
    logic            fd_active;
    rxafc_fd_state_t fd_state;
    rxafc_fd_state_t next_fd_state;
    logic            paused_sent;

    assign flow_high_level        = cfg[RXAFC_HI_LSB +: 8];
    assign flow_low_level         = cfg[RXAFC_LO_LSB +: 8];
    assign jam_duration           = cfg[RXAFC_DUR_LSB +: 4];
    assign trigger_on_multicast   = cfg[RXAFC_MULT_BIT];
    assign trigger_on_broadcast   = cfg[RXAFC_BRD_BIT];
    assign trigger_on_own_address = cfg[RXAFC_OWN_BIT];
    assign trigger_on_any_frame   = cfg[RXAFC_ANY_BIT];

    // APB decode: single zero-wait-state register
    assign apb_access = psel && penable;
    assign cfg_hit    = (paddr == RXAFC_CFG_OFFSET);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= RXAFC_CFG_RESET;
        end else if (apb_access && pwrite && cfg_hit) begin
            cfg <= pwdata[23:0];
        end
    end

    // Read data registered in setup phase so it stands at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite && cfg_hit) begin
            prdata <= {8'h00, cfg};
        end else if (psel && !penable) begin
            prdata <= 32'h00000000;
        end
    end

    // Ready and error answer in the access phase; unmapped address errors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !cfg_hit;
        end
    end

    assign above_high = ({6'h00, rx_fifo_bytes} >=
                         ({12'h000, flow_high_level} << RXAFC_UNIT_SHIFT));
    assign below_low  = ({6'h00, rx_fifo_bytes} <
                         ({12'h000, flow_low_level} << RXAFC_UNIT_SHIFT));

    assign fd_active = tx_enabled && full_duplex && trigger_on_any_frame;
    assign hd_active = tx_enabled && !full_duplex;

    always_comb begin
        if (trigger_on_any_frame) begin
            frame_match = rx_ev.preamble;
        end else begin
            frame_match = rx_ev.addr_valid &&
                          ((trigger_on_multicast && rx_ev.multicast) ||
                           (trigger_on_broadcast && rx_ev.broadcast) ||
                           (trigger_on_own_address && rx_ev.own_addr));
        end
    end

    assign jam_start = hd_active && above_high && frame_match;

    rxafc_jam_timer i_rxafc_jam_timer (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (jam_start),
        .code      (jam_duration),
        .speed_10m (speed_10m),
        .abort     (!hd_active),
        .busy      (jam_busy)
    );

    // Jam output registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jam <= 1'b0;
        end else begin
            jam <= jam_busy && hd_active;
        end
    end

    // Full-duplex pause sequencer
    always_comb begin
        next_fd_state = fd_state;
        case (fd_state)
            ST_IDLE: begin
                if (fd_active && above_high && rx_ev.preamble) begin
                    next_fd_state = ST_PAUSE;
                end
            end
            ST_PAUSE: begin
                if (!fd_active) begin
                    next_fd_state = ST_IDLE;
                end else if (pause_done) begin
                    next_fd_state = ST_PAUSED;
                end
            end
            ST_PAUSED: begin
                if (!fd_active) begin
                    next_fd_state = ST_IDLE;
                end else if (below_low && paused_sent) begin
                    next_fd_state = ST_RESUME;
                end
            end
            ST_RESUME: begin
                if (pause_done || !fd_active) begin
                    next_fd_state = ST_IDLE;
                end
            end
            default: begin
                next_fd_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fd_state <= ST_IDLE;
        end else begin
            fd_state <= next_fd_state;
        end
    end

    // Records that the pause frame really went out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            paused_sent <= 1'b0;
        end else if (fd_state == ST_PAUSE && pause_done) begin
            paused_sent <= 1'b1;
        end else if (fd_state == ST_IDLE) begin
            paused_sent <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_req  <= 1'b0;
            pause_time <= 16'h0000;
        end else begin
            pause_req  <= tx_enabled &&
                          (next_fd_state == ST_PAUSE || next_fd_state == ST_RESUME);
            pause_time <= (next_fd_state == ST_RESUME) ? 16'h0000 : pause_time_value;
        end
    end
endmodule

// >>> verilog/rxafc_jam_timer.sv
// Down-counter that times one back-pressure jam
`timescale 1ns/1ps
module rxafc_jam_timer
    import rxafc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [3:0]  code,
    input  wire logic        speed_10m,
    input  wire logic        abort,
    output logic             busy
);
    logic [16:0] count;
    logic [16:0] load_value;

    // Duration in cycles from the code, longer at 10 Mb/s
    always_comb begin
        load_value = 17'(rxafc_jam_us(code) * CLK_MHZ);
        if (speed_10m) begin
            load_value = 17'(rxafc_jam_us(code) * CLK_MHZ + JAM_EXTRA_CYC);
        end
    end

    // Load on start, count to zero, abort drops jam at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 17'h00000;
        end else if (abort) begin
            count <= 17'h00000;
        end else if (start) begin
            count <= load_value;
        end else if (count != 17'h00000) begin
            count <= count - 17'h00001;
        end
    end

    // Registered busy flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
        end else begin
            busy <= !abort && (start || count > 17'h00001);
        end
    end
endmodule

// >>> verilog/rxafc_pkg.sv
// Package with register map, field layout and timing constants of the receive flow controller
package rxafc_pkg;

    localparam logic [11:0] RXAFC_CFG_OFFSET = 12'h0AC;
    localparam int          RXAFC_HI_LSB     = 16;
    localparam int          RXAFC_LO_LSB     = 8;
    localparam int          RXAFC_DUR_LSB    = 4;
    localparam int          RXAFC_MULT_BIT   = 3;
    localparam int          RXAFC_BRD_BIT    = 2;
    localparam int          RXAFC_OWN_BIT    = 1;
    localparam int          RXAFC_ANY_BIT    = 0;
    localparam logic [23:0] RXAFC_CFG_RESET  = 24'h000000;
    localparam int          RXAFC_UNIT_SHIFT = 6;   // 64-byte units

    // Clock and jam timing, durations in nanoseconds
    localparam int CLK_MHZ          = 100;
    localparam int JAM_EXTRA_10M_NS = 2200;
    localparam int JAM_EXTRA_CYC    = JAM_EXTRA_10M_NS * CLK_MHZ / 1000;

    // Base jam time per duration code at 100 Mb/s, in microseconds
    function automatic int rxafc_jam_us(input logic [3:0] code);
        int us;
        us = 0;
        case (code)
            4'h0: us = 5;
            4'h1: us = 10;
            4'h2: us = 15;
            4'h3: us = 25;
            default: us = (int'(code) - 3) * 50;
        endcase
        return us;
    endfunction

    // Receive-side frame event from the MAC
    typedef struct packed {
        logic preamble;    // Valid preamble seen, start of frame
        logic addr_valid;  // Destination decode done
        logic multicast;
        logic broadcast;
        logic own_addr;
    } rxafc_rx_ev_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_PAUSE  = 4'b0010,
        ST_PAUSED = 4'b0100,
        ST_RESUME = 4'b1000
    } rxafc_fd_state_t;

endpackage
